//--- rtl/idata_pkg.sv
package idata_pkg;
	// address space shape
	localparam int unsigned IDATA_BYTES = 256;
	localparam int unsigned UPPER_BYTES = 128;
	localparam logic [7:0] UPPER_BASE = 8'h80;
	localparam logic [7:0] BITAREA_BASE = 8'h20;
	localparam logic [7:0] BITAREA_LAST = 8'h2F;
	localparam logic [7:0] STACK_FIRST = 8'h08;
	// register offsets
	localparam logic [7:0] OFS_PORT0 = 8'h80;
	localparam logic [7:0] OFS_SP = 8'h81;
	localparam logic [7:0] OFS_DP0L = 8'h82;
	localparam logic [7:0] OFS_DP0H = 8'h83;
	localparam logic [7:0] OFS_DP1L = 8'h84;
	localparam logic [7:0] OFS_DP1H = 8'h85;
	localparam logic [7:0] OFS_WDREL = 8'h86;
	localparam logic [7:0] OFS_USPD = 8'h87;
	localparam logic [7:0] OFS_TCTL = 8'h88;
	localparam logic [7:0] OFS_TMODE = 8'h89;
	localparam logic [7:0] OFS_T0L = 8'h8A;
	localparam logic [7:0] OFS_T1L = 8'h8B;
	localparam logic [7:0] OFS_T0H = 8'h8C;
	localparam logic [7:0] OFS_T1H = 8'h8D;
	localparam logic [7:0] OFS_STRETCH = 8'h8E;
	localparam logic [7:0] OFS_PORT1 = 8'h90;
	localparam logic [7:0] OFS_PSEL = 8'h92;
	localparam logic [7:0] OFS_S0CTL = 8'h98;
	localparam logic [7:0] OFS_S0BUFR = 8'h99;
	localparam logic [7:0] OFS_IE2 = 8'h9A;
	localparam logic [7:0] OFS_S1CTL = 8'h9B;
	localparam logic [7:0] OFS_S1BUFR = 8'h9C;
	localparam logic [7:0] OFS_S1RL = 8'h9D;
	localparam logic [7:0] OFS_PORT2 = 8'hA0;
	localparam logic [7:0] OFS_IE0 = 8'hA8;
	localparam logic [7:0] OFS_IPR0 = 8'hA9;
	localparam logic [7:0] OFS_S0RL = 8'hAA;
	localparam logic [7:0] OFS_PORT3 = 8'hB0;
	localparam logic [7:0] OFS_IE1 = 8'hB8;
	localparam logic [7:0] OFS_IPR1 = 8'hB9;
	localparam logic [7:0] OFS_S0RH = 8'hBA;
	localparam logic [7:0] OFS_S1RH = 8'hBB;
	localparam logic [7:0] OFS_PAGE = 8'hBF;
	localparam logic [7:0] OFS_IRQF = 8'hC0;
	localparam logic [7:0] OFS_PSW = 8'hD0;
	localparam logic [7:0] OFS_BAUD = 8'hD8;
	localparam logic [7:0] OFS_ACC = 8'hE0;
	localparam logic [7:0] OFS_BREG = 8'hF0;
	// reset values
	localparam logic [7:0] RST_PORT = 8'hFF;
	localparam logic [7:0] RST_PORT2 = 8'h00;
	localparam logic [7:0] RST_SP = 8'h07;
	localparam logic [7:0] RST_STRETCH = 8'h01;
	localparam logic [7:0] RST_S0RL = 8'hD9;
	localparam logic [7:0] RST_RELH = 8'h03;
	localparam logic [7:0] RST_ZERO = 8'h00;
	// field positions
	localparam int unsigned PSW_BANK_LSB = 3;
	localparam int unsigned PSEL_BIT = 0;
	localparam int unsigned BAUD_BIT = 7;
	// access modes of the core
	typedef enum logic {MODE_DIRECT, MODE_INDIRECT} mode_t;
endpackage : idata_pkg

//--- rtl/idata_ram.sv
`timescale 1ns/10ps
`default_nettype none
// 256 bytes of RAM: low half shared, high half reached only indirectly
module idata_ram
	import idata_pkg::*;
(
	input wire logic clk,
	input wire logic ce,
	input wire logic wr_en,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	output logic [7:0] rdata
);
	logic [7:0] mem [0:IDATA_BYTES-1];

	// registered read, write-first so a same-cycle write is seen
	always_ff @(posedge clk) begin
		if (ce) begin
			if (wr_en) begin
				mem[addr] <= wdata;
				rdata <= wdata;
			end else begin
				rdata <= mem[addr];
			end
		end
	end
endmodule : idata_ram
`default_nettype wire

//--- rtl/idata_space.sv
// Function
// - internal data space holds 256 bytes, addresses 0x00 to 0xFF.
// - every access carries one address byte; direct and indirect modes accepted.
// - direct access at 0x80 and above goes to special registers.
// - indirect access at 0x80 and above goes to separate upper RAM.
// - lowest 32 bytes are four banks of eight working registers.
// - two status word bits choose the active bank.
// - bank 0..3 maps working registers to 0x00, 0x08, 0x10, 0x18.
// - bytes 0x20-0x2F are bit addressable, bit addresses 0x00-0x7F.
// - lower 128 bytes behave the same under direct and indirect access.
// - reads of unimplemented special addresses return 0x00.
// - writes to unimplemented special addresses change nothing.
// - special registers at addresses ending in 000 allow bit access.
// - every generic special register loads its reset value.
// - baud rate select keeps only bit 7.
// - paged address register supplies upper byte for paged external moves.
// - pointer select bit 0 chooses primary or secondary data pointer.
// - stack pointer resets to 0x07; pre-increment puts first push at 0x08.
`timescale 1ns/10ps
`default_nettype none
module idata_space
	import idata_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic acc_valid,
	input wire logic acc_write,
	input wire logic acc_indirect,
	input wire logic [7:0] acc_addr,
	input wire logic [7:0] acc_wdata,
	input wire logic reg_idx_en,
	input wire logic [2:0] reg_idx,
	input wire logic bit_en,
	input wire logic [7:0] bit_addr,
	input wire logic bit_value,
	output logic [7:0] rd_data,
	output logic rd_valid,
	output logic [2:0] rd_bit_pos,
	output logic [1:0] active_bank,
	output logic [15:0] data_pointer_active,
	output logic [7:0] paged_address_high,
	output logic [7:0] stack_pointer,
	output logic baud_rate_double
);
	// bit address to byte address: low half into RAM block, high half into special rows
	function automatic logic [7:0] bit_to_byte(input logic [7:0] b);
		if (b[7])
			bit_to_byte = {b[7:3], 3'b000};
		else
			bit_to_byte = BITAREA_BASE + {4'h0, b[6:3]};
	endfunction : bit_to_byte

	// known special register offsets
	function automatic logic sfr_known(input logic [7:0] a);
		case (a)
			OFS_PORT0, OFS_SP, OFS_DP0L, OFS_DP0H, OFS_DP1L, OFS_DP1H, OFS_WDREL,
			OFS_USPD, OFS_TCTL, OFS_TMODE, OFS_T0L, OFS_T1L, OFS_T0H, OFS_T1H,
			OFS_STRETCH, OFS_PORT1, OFS_PSEL, OFS_S0CTL, OFS_S0BUFR, OFS_IE2,
			OFS_S1CTL, OFS_S1BUFR, OFS_S1RL, OFS_PORT2, OFS_IE0, OFS_IPR0,
			OFS_S0RL, OFS_PORT3, OFS_IE1, OFS_IPR1, OFS_S0RH, OFS_S1RH, OFS_PAGE,
			OFS_IRQF, OFS_PSW, OFS_BAUD, OFS_ACC, OFS_BREG: sfr_known = 1'b1;
			default: sfr_known = 1'b0;
		endcase
	endfunction : sfr_known

	logic [7:0] sfr_q [0:UPPER_BYTES-1];
	logic [7:0] eff_addr;
	logic eff_write;
	logic [7:0] eff_wdata;
	logic to_sfr;
	logic ram_we;
	logic [7:0] ram_rdata;
	logic [7:0] cur_byte;
	logic [7:0] sfr_rd;
	logic sel_sfr_q;
	logic [7:0] sfr_rd_q;
	logic [1:0] bank_sel;
	mode_t mode;
	// combinational copy of the RAM, needed to merge a single bit in the same cycle
	logic [7:0] ram_shadow [0:IDATA_BYTES-1];
	logic [7:0] ram_rdata_comb;

	assign mode = acc_indirect ? MODE_INDIRECT : MODE_DIRECT;
	assign bank_sel = sfr_q[OFS_PSW[6:0]][PSW_BANK_LSB +: 2];

	// resolve the single address byte from byte, working-register or bit access
	always_comb begin
		eff_addr = acc_addr;
		eff_write = acc_write;
		eff_wdata = acc_wdata;
		if (reg_idx_en)
			eff_addr = {3'b000, bank_sel, reg_idx};
		else if (bit_en)
			eff_addr = bit_to_byte(bit_addr);
		if (bit_en) begin
			eff_write = acc_write;
			eff_wdata = cur_byte;
			eff_wdata[bit_addr[2:0]] = bit_value;
		end
	end

	// special space only for direct mode with bit 7 set; bit access is direct
	assign to_sfr = eff_addr[7] && (mode == MODE_DIRECT || bit_en);
	// lower half and indirect upper half share one RAM, same location either mode
	assign ram_we = acc_valid && eff_write && !to_sfr && ce;

	// current byte for read-modify-write of a single bit
	assign sfr_rd = sfr_known(eff_addr) ? sfr_q[eff_addr[6:0]] : RST_ZERO;
	always_comb begin
		cur_byte = sfr_rd;
		if (!to_sfr)
			cur_byte = ram_rdata_comb;
	end

	// shadow tracks every RAM write; the block RAM answers byte reads
	assign ram_rdata_comb = ram_shadow[eff_addr];
	always_ff @(posedge clk) begin
		if (ram_we)
			ram_shadow[eff_addr] <= eff_wdata;
	end

	idata_ram u_ram (
		.clk(clk),
		.ce(ce && acc_valid),
		.wr_en(eff_write && !to_sfr),
		.addr(eff_addr),
		.wdata(eff_wdata),
		.rdata(ram_rdata)
	);

	// special register file with documented reset values
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			for (int i = 0; i < UPPER_BYTES; i++)
				sfr_q[i] <= RST_ZERO;
			sfr_q[OFS_PORT0[6:0]] <= RST_PORT;
			sfr_q[OFS_PORT1[6:0]] <= RST_PORT;
			sfr_q[OFS_PORT3[6:0]] <= RST_PORT;
			sfr_q[OFS_PORT2[6:0]] <= RST_PORT2;
			sfr_q[OFS_SP[6:0]] <= RST_SP;
			sfr_q[OFS_STRETCH[6:0]] <= RST_STRETCH;
			sfr_q[OFS_S0RL[6:0]] <= RST_S0RL;
			sfr_q[OFS_S0RH[6:0]] <= RST_RELH;
			sfr_q[OFS_S1RH[6:0]] <= RST_RELH;
		end else if (ce && acc_valid && eff_write && to_sfr && sfr_known(eff_addr)) begin
			if (eff_addr == OFS_BAUD)
				sfr_q[eff_addr[6:0]] <= {eff_wdata[BAUD_BIT], 7'h00};
			else
				sfr_q[eff_addr[6:0]] <= eff_wdata;
		end
	end

	// read path: remember which side answers, register the special value
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sel_sfr_q <= 1'b0;
			sfr_rd_q <= RST_ZERO;
			rd_valid <= 1'b0;
			rd_bit_pos <= 3'h0;
		end else if (ce) begin
			sel_sfr_q <= to_sfr;
			sfr_rd_q <= sfr_rd;
			rd_valid <= acc_valid && !eff_write;
			rd_bit_pos <= bit_addr[2:0];
		end
	end
	assign rd_data = sel_sfr_q ? sfr_rd_q : ram_rdata;

	// status views for the core
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			active_bank <= 2'h0;
			data_pointer_active <= 16'h0000;
			paged_address_high <= RST_ZERO;
			stack_pointer <= RST_SP;
			baud_rate_double <= 1'b0;
		end else if (ce) begin
			active_bank <= bank_sel;
			if (sfr_q[OFS_PSEL[6:0]][PSEL_BIT])
				data_pointer_active <= {sfr_q[OFS_DP1H[6:0]], sfr_q[OFS_DP1L[6:0]]};
			else
				data_pointer_active <= {sfr_q[OFS_DP0H[6:0]], sfr_q[OFS_DP0L[6:0]]};
			paged_address_high <= sfr_q[OFS_PAGE[6:0]];
			stack_pointer <= sfr_q[OFS_SP[6:0]];
			baud_rate_double <= sfr_q[OFS_BAUD[6:0]][BAUD_BIT];
		end
	end

	// checks
	AST_SP_RESET: assert property (@(posedge clk) $rose(rst_n) |-> stack_pointer == RST_SP)
		else $error("stack pointer not 0x07 after reset");
	AST_PUSH_FIRST: assert property (@(posedge clk) disable iff (!rst_n)
		(stack_pointer == RST_SP) |-> (stack_pointer + 8'h01 == STACK_FIRST))
		else $error("first push slot wrong");
	AST_BANK: assert property (@(posedge clk) disable iff (!rst_n)
		reg_idx_en |-> eff_addr == {3'b000, bank_sel, reg_idx})
		else $error("working register address wrong");
	AST_INDIRECT_RAM: assert property (@(posedge clk) disable iff (!rst_n)
		(acc_valid && acc_indirect && !bit_en) |-> !to_sfr)
		else $error("indirect access reached special space");
	AST_DIRECT_SFR: assert property (@(posedge clk) disable iff (!rst_n)
		(acc_valid && !acc_indirect && !reg_idx_en && !bit_en && acc_addr[7]) |-> to_sfr)
		else $error("direct upper access missed special space");
	AST_UNIMPL_WRITE: assert property (@(posedge clk) disable iff (!rst_n)
		(ce && acc_valid && acc_write && to_sfr && !sfr_known(eff_addr)) |=> $stable(stack_pointer))
		else $error("unimplemented write changed state");
	AST_BIT_LOW: assert property (@(posedge clk) disable iff (!rst_n)
		(bit_en && !bit_addr[7] && !reg_idx_en) |-> (eff_addr >= BITAREA_BASE && eff_addr <= BITAREA_LAST))
		else $error("bit address outside bit area");
	AST_BAUD: assert property (@(posedge clk) disable iff (!rst_n)
		sfr_q[OFS_BAUD[6:0]][6:0] == 7'h00)
		else $error("baud select low bits set");
	COV_BANK3: cover property (@(posedge clk) reg_idx_en && bank_sel == 2'h3);
	COV_INDIRECT_HI: cover property (@(posedge clk) acc_valid && acc_indirect && acc_addr[7]);
	COV_BITSET: cover property (@(posedge clk) bit_en && acc_write && bit_addr[7]);
endmodule : idata_space
`default_nettype wire

//--- verif/core_model.sv
`timescale 1ns/10ps
`default_nettype none
// core side of the data space: one request per call, taken at the edge after it is set up
module core_model (
	input wire logic clk,
	output logic acc_valid,
	output logic acc_write,
	output logic acc_indirect,
	output logic [7:0] acc_addr,
	output logic [7:0] acc_wdata,
	output logic reg_idx_en,
	output logic [2:0] reg_idx,
	output logic bit_en,
	output logic [7:0] bit_addr,
	output logic bit_value,
	input wire logic [7:0] rd_data,
	input wire logic rd_valid
);
	// idle lines start at a definite level so nothing floats into the decoder
	initial begin
		{acc_valid, acc_write, acc_indirect, reg_idx_en, bit_en, bit_value} = 6'h00;
		{acc_addr, acc_wdata, bit_addr} = 24'h000000;
		reg_idx = 3'h0;
	end
	// released address, write data, bit address and bit value show the inverse of their last value; write, mode and register index keep theirs
	task automatic access(input logic wr, input logic ind, input logic [7:0] a, input logic [7:0] wd,
		input logic ri_en, input logic [2:0] ri, input logic b_en, input logic bv);
		@(posedge clk);
		#1;
		{acc_valid, acc_write, acc_indirect, acc_addr, acc_wdata} = {1'b1, wr, ind, a, wd};
		{reg_idx_en, reg_idx, bit_en, bit_addr, bit_value} = {ri_en, ri, b_en, a, bv};
		@(posedge clk);
		#1;
		{acc_valid, reg_idx_en, bit_en} = 3'h0;
		acc_addr = ~acc_addr;
		acc_wdata = ~acc_wdata;
		bit_addr = ~bit_addr;
		bit_value = ~bit_value;
	endtask : access
	// the answer stands for one cycle, so it is taken right after the taking edge
	task automatic rd(input logic ind, input logic [7:0] a, input logic ri_en, input logic [2:0] ri,
		output logic [7:0] d, output logic v);
		access(1'b0, ind, a, ~a, ri_en, ri, 1'b0, 1'b0);
		d = rd_data;
		v = rd_valid;
	endtask : rd
endmodule : core_model
`default_nettype wire

//--- verif/tb_idata_space.sv
`timescale 1ns/10ps
`default_nettype none
module tb_idata_space
	import idata_pkg::*;
;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic ce = 1'b1;
	wire logic acc_valid, acc_write, acc_indirect, reg_idx_en, bit_en, bit_value;
	wire logic [7:0] acc_addr, acc_wdata, bit_addr;
	wire logic [2:0] reg_idx;
	logic [7:0] rd_data, paged_address_high, stack_pointer;
	logic rd_valid, baud_rate_double;
	logic [2:0] rd_bit_pos;
	logic [1:0] active_bank;
	logic [15:0] data_pointer_active;
	int failures = 0;
	int check_count = 0;
	int cycles = 0;
	logic [7:0] rst_ofs [0:9] = '{8'h80, 8'h81, 8'h82, 8'h8E, 8'h90, 8'hA0, 8'hAA, 8'hB0, 8'hBA, 8'hBB};
	logic [7:0] rst_val [0:9] = '{8'hFF, 8'h07, 8'h00, 8'h01, 8'hFF, 8'h00, 8'hD9, 8'hFF, 8'h03, 8'h03};

	always #5 clk = ~clk;

	idata_space dut (.clk(clk), .rst_n(rst_n), .ce(ce), .acc_valid(acc_valid), .acc_write(acc_write),
		.acc_indirect(acc_indirect), .acc_addr(acc_addr), .acc_wdata(acc_wdata), .reg_idx_en(reg_idx_en),
		.reg_idx(reg_idx), .bit_en(bit_en), .bit_addr(bit_addr), .bit_value(bit_value), .rd_data(rd_data),
		.rd_valid(rd_valid), .rd_bit_pos(rd_bit_pos), .active_bank(active_bank),
		.data_pointer_active(data_pointer_active), .paged_address_high(paged_address_high),
		.stack_pointer(stack_pointer), .baud_rate_double(baud_rate_double));
	core_model core (.clk(clk), .acc_valid(acc_valid), .acc_write(acc_write), .acc_indirect(acc_indirect),
		.acc_addr(acc_addr), .acc_wdata(acc_wdata), .reg_idx_en(reg_idx_en), .reg_idx(reg_idx),
		.bit_en(bit_en), .bit_addr(bit_addr), .bit_value(bit_value), .rd_data(rd_data), .rd_valid(rd_valid));

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", check_count, failures);
		if (failures == 0 && check_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : wrap_up
	task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
		check_count++;
		if (g !== e) begin
			failures++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask : chk8
	task automatic chk16(input string n, input logic [15:0] e, input logic [15:0] g);
		check_count++;
		if (g !== e) begin
			failures++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask : chk16
	task automatic wr(input logic ind, input logic [7:0] a, input logic [7:0] v);
		core.access(1'b1, ind, a, v, 1'b0, 3'h0, 1'b0, 1'b0);
	endtask : wr
	// status views trail the register write by one more edge
	task automatic settle();
		@(posedge clk);
		#1;
	endtask : settle
	// read and compare; every answer must also be flagged valid
	task automatic rx(input logic ind, input logic [7:0] a, input logic ri_en, input logic [2:0] ri,
		input logic [7:0] e);
		logic [7:0] d;
		logic v;
		core.rd(ind, a, ri_en, ri, d, v);
		chk8("rd_valid", 8'h01, {7'h00, v});
		chk8("rd_data", e, d);
	endtask : rx

	// hang guard: the whole sequence needs well under a thousand cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			failures++;
			wrap_up();
		end
	end

	initial begin
		repeat (5) @(posedge clk);
		#1;
		rst_n = 1'b1;
		for (int i = 0; i < 10; i++) rx(1'b0, rst_ofs[i], 1'b0, 3'h0, rst_val[i]);
		chk8("stack_pointer", 8'h07, stack_pointer);
		$display("test reset_values done");
		// same address, two modes: must land in two different places
		wr(1'b0, 8'hE0, 8'h11);
		wr(1'b1, 8'hE0, 8'h22);
		rx(1'b0, 8'hE0, 1'b0, 3'h0, 8'h11);
		rx(1'b1, 8'hE0, 1'b0, 3'h0, 8'h22);
		wr(1'b0, 8'h45, 8'h33);
		rx(1'b1, 8'h45, 1'b0, 3'h0, 8'h33);
		// a write to a hole in the special space must not leak into upper RAM
		wr(1'b1, 8'hC8, 8'h99);
		wr(1'b0, 8'hC8, 8'h55);
		rx(1'b1, 8'hC8, 1'b0, 3'h0, 8'h99);
		$display("test routing done");
		for (int b = 0; b < 4; b++) begin
			wr(1'b0, 8'hD0, 8'(b << 3));
			wr(1'b0, 8'(b * 8 + 5), 8'(8'hA0 + b));
			rx(1'b0, 8'h00, 1'b1, 3'h5, 8'(8'hA0 + b));
			chk8("active_bank", 8'(b), {6'h00, active_bank});
		end
		$display("test banks done");
		wr(1'b0, 8'h21, 8'h00);
		core.access(1'b1, 1'b0, 8'h0B, 8'h00, 1'b0, 3'h0, 1'b1, 1'b1);
		rx(1'b0, 8'h21, 1'b0, 3'h0, 8'h08);
		core.access(1'b1, 1'b0, 8'h91, 8'h00, 1'b0, 3'h0, 1'b1, 1'b0);
		rx(1'b0, 8'h90, 1'b0, 3'h0, 8'hFD);
		$display("test bits done");
		wr(1'b0, 8'hD8, 8'hFF);
		rx(1'b0, 8'hD8, 1'b0, 3'h0, 8'h80);
		chk8("baud_rate_double", 8'h01, {7'h00, baud_rate_double});
		wr(1'b0, 8'hBF, 8'h5C);
		settle();
		chk8("paged_address_high", 8'h5C, paged_address_high);
		wr(1'b0, 8'h81, 8'h30);
		settle();
		chk8("stack_pointer", 8'h30, stack_pointer);
		// both pointers loaded before switching, so a stuck select shows
		wr(1'b0, 8'h82, 8'h34);
		wr(1'b0, 8'h83, 8'h12);
		wr(1'b0, 8'h84, 8'hCD);
		wr(1'b0, 8'h85, 8'hAB);
		wr(1'b0, 8'h92, 8'h01);
		settle();
		chk16("data_pointer_active", 16'hABCD, data_pointer_active);
		wr(1'b0, 8'h92, 8'h00);
		settle();
		chk16("data_pointer_active", 16'h1234, data_pointer_active);
		$display("test views done");
		wrap_up();
	end
endmodule : tb_idata_space
`default_nettype wire
